/* File: rtl/ecct_pkg.sv */
// Package: constants and encodings for the edge-clear capture timer
package ecct_pkg;
    // Mode field values (bits 3:2 of timer mode control)
    localparam logic [1:0] MODE_EDGE_CLEAR = 2'h2;
    // Clock select values (prescaler mode bits 1:0)
    localparam logic [1:0] CLKSEL_DIV1     = 2'h0;
    localparam logic [1:0] CLKSEL_DIV2     = 2'h1;
    localparam logic [1:0] CLKSEL_DIV4     = 2'h2;
    localparam logic [1:0] CLKSEL_TRIGGER  = 2'h3;
    // Edge select encodings (falling, rising, none, both)
    localparam logic [1:0] EDGE_FALL       = 2'h0;
    localparam logic [1:0] EDGE_RISE       = 2'h1;
    localparam logic [1:0] EDGE_NONE       = 2'h2;
    localparam logic [1:0] EDGE_BOTH       = 2'h3;
    // Reset values
    localparam logic [15:0] COUNT_RESET    = 16'h0000;
    localparam logic [15:0] CAPREG_RESET   = 16'h0000;
    localparam logic        PIN_RESET      = 1'h0;
    // Prescaler divider width
    localparam int          PRESCALE_W     = 2;
endpackage : ecct_pkg

/* File: rtl/ecct_edge_detect.sv */
// Two-sample edge detector for one trigger pin
`timescale 1ns/1ps
`default_nettype none
module ecct_edge_detect (
    // Clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // Sampling
    input  wire logic       sample_en_i,
    input  wire logic       pin_i,
    input  wire logic [1:0] edge_sel_i,
    // Detected edges
    output logic            valid_o,
    output logic            reverse_o
);
    typedef struct packed {
        logic       sync1;
        logic       sync2;
        logic [1:0] hist;
        logic       stable;
        logic       valid;
        logic       reverse;
    } ecct_ed_type;

    ecct_ed_type st;
    ecct_ed_type next_st;
    logic        rise;
    logic        fall;

    always_comb begin
        next_st         = st;
        next_st.sync1   = pin_i;
        next_st.sync2   = st.sync1;
        next_st.valid   = 1'b0;
        next_st.reverse = 1'b0;
        rise            = 1'b0;
        fall            = 1'b0;
        if (sample_en_i) begin
            next_st.hist = {st.hist[0], st.sync2};
            // Level accepted only when two samples agree; filters short glitches
            if (st.hist[0] == st.sync2) begin
                next_st.stable = st.sync2;
                rise = st.sync2 & ~st.stable;
                fall = ~st.sync2 & st.stable;
            end
            case (edge_sel_i)
                ecct_pkg::EDGE_FALL: begin
                    next_st.valid   = fall;
                    next_st.reverse = rise;
                end
                ecct_pkg::EDGE_RISE: begin
                    next_st.valid   = rise;
                    next_st.reverse = fall;
                end
                ecct_pkg::EDGE_BOTH: begin
                    next_st.valid   = rise | fall;
                    next_st.reverse = rise | fall;
                end
                default: begin
                    next_st.valid   = 1'b0;
                    next_st.reverse = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign valid_o   = st.valid;
    assign reverse_o = st.reverse;
endmodule : ecct_edge_detect
`default_nettype wire

/* File: rtl/ecct_timer.sv */
// Top: 16-bit timer cleared and restarted by trigger edge, two capture/compare registers
`timescale 1ns/1ps
`default_nettype none
module ecct_timer (
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        rst_i,
    // Mode control
    input  wire logic        mode_field_high_i,
    input  wire logic        mode_field_low_i,
    input  wire logic        edge_toggle_enable_i,
    // Prescaler
    input  wire logic        clock_select_high_i,
    input  wire logic        clock_select_low_i,
    input  wire logic [1:0]  primary_edge_sel_i,
    input  wire logic        secondary_edge_sel_high_i,
    input  wire logic        secondary_edge_sel_low_i,
    // Capture/compare control
    input  wire logic        capcomp_zero_capture_i,
    input  wire logic        reverse_phase_capture_sel_i,
    input  wire logic        capcomp_one_capture_i,
    // Compare value writes
    input  wire logic        capcomp_reg_zero_we_i,
    input  wire logic [15:0] capcomp_reg_zero_wdata_i,
    input  wire logic        capcomp_reg_one_we_i,
    input  wire logic [15:0] capcomp_reg_one_wdata_i,
    // Pins
    input  wire logic        primary_trigger_pin_i,
    input  wire logic        secondary_trigger_pin_i,
    output logic             timer_output_pin_o,
    // State and events
    output logic [15:0]      up_counter_o,
    output logic [15:0]      capcomp_reg_zero_o,
    output logic [15:0]      capcomp_reg_one_o,
    output logic             event_zero_o,
    output logic             event_one_o
);
    localparam int PRESCALE_W_L = ecct_pkg::PRESCALE_W;

    typedef struct packed {
        logic [PRESCALE_W_L-1:0] div;
        logic [15:0]             counter;
        logic [15:0]             reg_zero;
        logic [15:0]             reg_one;
        logic                    out_pin;
        logic                    ev_zero;
        logic                    ev_one;
    } ecct_top_type;

    ecct_top_type st;
    ecct_top_type next_st;
    logic [1:0]   mode;
    logic [1:0]   clk_sel;
    logic [1:0]   sec_sel;
    logic         prim_valid;
    logic         prim_rev;
    logic         sec_valid;
    logic         tick;
    logic         active;
    logic         match_zero;
    logic         match_one;
    logic         cap_one;
    logic         sec_in_use;
    logic         match_toggle;
    logic         edge_toggle;

    assign mode    = {mode_field_high_i, mode_field_low_i};
    assign clk_sel = {clock_select_high_i, clock_select_low_i};
    assign sec_sel = {secondary_edge_sel_high_i, secondary_edge_sel_low_i};

    // Pins sampled every reference cycle (prescaler source rate)
    ecct_edge_detect u_prim (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .sample_en_i (1'b1),
        .pin_i       (primary_trigger_pin_i),
        .edge_sel_i  (primary_edge_sel_i),
        .valid_o     (prim_valid),
        .reverse_o   (prim_rev)
    );

    ecct_edge_detect u_sec (
        .ref_clk_i   (ref_clk_i),
        .rst_i       (rst_i),
        .sample_en_i (1'b1),
        .pin_i       (secondary_trigger_pin_i),
        .edge_sel_i  (sec_sel),
        .valid_o     (sec_valid),
        .reverse_o   ()
    );

    always_comb begin
        next_st         = st;
        next_st.ev_zero = 1'b0;
        next_st.ev_one  = 1'b0;
        active          = (mode == ecct_pkg::MODE_EDGE_CLEAR);
        // Divider idles at zero so every mode entry starts on a clean phase
        if (active) begin
            next_st.div = st.div + 1'b1;
        end else begin
            next_st.div = '0;
        end
        case (clk_sel)
            ecct_pkg::CLKSEL_DIV1: begin
                tick = active;
            end
            ecct_pkg::CLKSEL_DIV2: begin
                tick = active & (st.div[0] == 1'b1);
            end
            ecct_pkg::CLKSEL_DIV4: begin
                tick = active & (st.div == '1);
            end
            ecct_pkg::CLKSEL_TRIGGER: begin
                tick = active & prim_valid;
            end
            default: begin
                tick = 1'b0;
            end
        endcase
        sec_in_use = (sec_sel != ecct_pkg::EDGE_NONE);
        match_zero = active & ~capcomp_zero_capture_i & (st.counter == st.reg_zero);
        match_one  = active & ~capcomp_one_capture_i & (st.counter == st.reg_one);
        cap_one    = active & capcomp_one_capture_i & prim_valid;

        // Writes ignored while a register captures
        if (capcomp_reg_zero_we_i && !capcomp_zero_capture_i) begin
            next_st.reg_zero = capcomp_reg_zero_wdata_i;
        end
        if (capcomp_reg_one_we_i && !capcomp_one_capture_i) begin
            next_st.reg_one = capcomp_reg_one_wdata_i;
        end

        if (!active) begin
            next_st.counter = ecct_pkg::COUNT_RESET;
        end else if (clk_sel == ecct_pkg::CLKSEL_TRIGGER) begin
            // Misuse: trigger edge as count clock holds the counter cleared
            next_st.counter = ecct_pkg::COUNT_RESET;
        end else if (prim_valid) begin
            next_st.counter = ecct_pkg::COUNT_RESET;
        end else if (tick) begin
            // Counts from entry, wraps on overflow
            next_st.counter = st.counter + 16'h0001;
        end

        // Compare events, counter untouched
        if (match_zero && tick) begin
            next_st.ev_zero = 1'b1;
        end
        if (match_one && tick) begin
            next_st.ev_one = 1'b1;
        end

        // Register zero trigger: secondary pin, or reverse phase of primary
        if (active && capcomp_zero_capture_i) begin
            if (reverse_phase_capture_sel_i) begin
                if (prim_rev) begin
                    next_st.reg_zero = st.counter;
                end
                if (sec_valid) begin
                    next_st.ev_zero = 1'b1;
                end
            end else if (sec_valid) begin
                next_st.reg_zero = st.counter;
                next_st.ev_zero  = 1'b1;
            end
        end else if (active && sec_valid) begin
            next_st.ev_zero = 1'b1;
        end

        // Capture takes the count from before the same-edge clear
        if (cap_one) begin
            next_st.reg_one = st.counter;
            next_st.ev_one  = 1'b1;
        end

        // Match and edge in one cycle cancel: two toggles leave the pin as it was
        match_toggle = (match_zero || match_one) && tick;
        edge_toggle  = edge_toggle_enable_i && prim_valid;
        // Output pin unusable while secondary edges are watched
        if (!active || sec_in_use) begin
            next_st.out_pin = ecct_pkg::PIN_RESET;
        end else if (match_toggle ^ edge_toggle) begin
            next_st.out_pin = ~st.out_pin;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            st          <= '0;
            st.counter  <= ecct_pkg::COUNT_RESET;
            st.reg_zero <= ecct_pkg::CAPREG_RESET;
            st.reg_one  <= ecct_pkg::CAPREG_RESET;
            st.out_pin  <= ecct_pkg::PIN_RESET;
        end else begin
            st <= next_st;
        end
    end

    // All outputs straight from the state register
    assign timer_output_pin_o = st.out_pin;
    assign up_counter_o       = st.counter;
    assign capcomp_reg_zero_o = st.reg_zero;
    assign capcomp_reg_one_o  = st.reg_one;
    assign event_zero_o       = st.ev_zero;
    assign event_one_o        = st.ev_one;
endmodule : ecct_timer
`default_nettype wire

/* File: tb/ecct_timer_monitor.sv */
// Assertion checker bound to the edge-clear capture timer
`timescale 1ns/1ps
`default_nettype none
module ecct_monitor (
    // Clock and reset
    input wire logic        ref_clk_i,
    input wire logic        rst_i,
    // Controls
    input wire logic        mode_field_high_i,
    input wire logic        mode_field_low_i,
    input wire logic        edge_toggle_enable_i,
    input wire logic        clock_select_high_i,
    input wire logic        clock_select_low_i,
    input wire logic        secondary_edge_sel_high_i,
    input wire logic        secondary_edge_sel_low_i,
    input wire logic        capcomp_zero_capture_i,
    input wire logic        reverse_phase_capture_sel_i,
    input wire logic        capcomp_one_capture_i,
    input wire logic        capcomp_reg_zero_we_i,
    // Outputs
    input wire logic        timer_output_pin_o,
    input wire logic [15:0] up_counter_o,
    input wire logic [15:0] capcomp_reg_zero_o,
    input wire logic        event_zero_o,
    input wire logic        event_one_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    wire logic [1:0] mode = {mode_field_high_i, mode_field_low_i};
    wire logic [1:0] csel = {clock_select_high_i, clock_select_low_i};
    wire logic [1:0] ssel = {secondary_edge_sel_high_i, secondary_edge_sel_low_i};
    sequence s_run;
        mode == 2'h2 && csel == 2'h0;
    endsequence
    sequence s_match0;
        s_run ##0 (!capcomp_zero_capture_i && up_counter_o == capcomp_reg_zero_o);
    endsequence
    a_count_up: assert property (s_run ##1 s_run |-> up_counter_o == 16'($past(up_counter_o) + 16'h1) || up_counter_o == 16'h0)
        else $error("counter did not step");
    a_start_now: assert property ((mode != 2'h2) ##1 s_run [*3] |-> up_counter_o != 16'h0)
        else $error("counter idle after mode entry");
    a_sel_held: assert property (csel == 2'h3 |=> up_counter_o == 16'h0)
        else $error("counter moved under pin clock");
    a_cap_clear: assert property (event_one_o && capcomp_one_capture_i |-> up_counter_o == 16'h0)
        else $error("counter not cleared on capture");
    a_match_event: assert property (s_match0 |=> event_zero_o)
        else $error("compare match gave no event");
    a_cap_event: assert property ($changed(capcomp_reg_zero_o) && capcomp_zero_capture_i && !reverse_phase_capture_sel_i |-> event_zero_o)
        else $error("capture without event");
    a_rev_quiet: assert property ($changed(capcomp_reg_zero_o) && capcomp_zero_capture_i && reverse_phase_capture_sel_i && ssel == 2'h2 |-> !event_zero_o)
        else $error("reverse capture raised event");
    a_reg_source: assert property ($changed(capcomp_reg_zero_o) |-> $past(capcomp_zero_capture_i) || $past(capcomp_reg_zero_we_i))
        else $error("register zero changed without cause");
    a_pin_off: assert property ((ssel != 2'h2) [*2] |-> timer_output_pin_o == 1'b0)
        else $error("output pin active with secondary in use");
    a_pin_cause: assert property ($changed(timer_output_pin_o) && $past(ssel) == 2'h2 && !$past(edge_toggle_enable_i) |-> event_zero_o || event_one_o)
        else $error("output pin toggled without match");
endmodule : ecct_monitor
bind ecct_timer ecct_monitor u_mon (.*);
`default_nettype wire

/* File: tb/ecct_pulse_src.sv */
// Pulse source model driving the two trigger pins
`timescale 1ns/1ps
`default_nettype none
module ecct_pulse_src (
    // Clock
    input wire logic ref_clk_i,
    // Trigger pins
    output logic     pri_pin_o,
    output logic     sec_pin_o
);
    initial {pri_pin_o, sec_pin_o} = 2'h0;
    // Called on a falling edge; level then held for whole cycles
    task drive(input bit sec, input logic lvl, input int hold);
        if (sec)
            sec_pin_o = lvl;
        else
            pri_pin_o = lvl;
        repeat (hold) @(negedge ref_clk_i);
    endtask : drive
endmodule : ecct_pulse_src
`default_nettype wire

/* File: tb/test_edge_clear_capture_timer.sv */
// Self-checking bench for the edge-clear capture timer
`timescale 1ns/1ps
`default_nettype none
module test_edge_clear_capture_timer;
    logic        ref_clk_i = 0, rst_i = 1, mode_field_high_i = 0, mode_field_low_i = 0, edge_toggle_enable_i = 0;
    logic        clock_select_high_i = 0, clock_select_low_i = 0, capcomp_reg_zero_we_i = 0, capcomp_reg_one_we_i = 0;
    logic        secondary_edge_sel_high_i = 1, secondary_edge_sel_low_i = 0, capcomp_zero_capture_i = 1;
    logic        reverse_phase_capture_sel_i = 0, capcomp_one_capture_i = 1, primary_trigger_pin_i;
    logic        secondary_trigger_pin_i, timer_output_pin_o, event_zero_o, event_one_o;
    logic [1:0]  primary_edge_sel_i = 2'h1;
    logic [15:0] capcomp_reg_zero_wdata_i = 16'h0040, capcomp_reg_one_wdata_i = 16'h0000;
    logic [15:0] up_counter_o, capcomp_reg_zero_o, capcomp_reg_one_o, v;
    int          failures = 0, samples_checked = 0, n0 = 0, n1 = 0, e;
    always #2.5 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) n0 <= n0 + int'(event_zero_o === 1'b1);
    always @(posedge ref_clk_i) n1 <= n1 + int'(event_one_o === 1'b1);
    ecct_timer uut (.*);
    ecct_pulse_src src (.ref_clk_i(ref_clk_i), .pri_pin_o(primary_trigger_pin_i), .sec_pin_o(secondary_trigger_pin_i));
    task cyc(input int k);
        repeat (k) @(negedge ref_clk_i);
    endtask : cyc
    task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task end_sim;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim
    // Bounded wait for an event pulse; a miss ends the run
    task wait_ev(input bit one);
        for (int i = 0; i < 100 && (one ? event_one_o : event_zero_o) !== 1'b1; i++)
            cyc(1);
        chk("event seen", 16'h1, {15'h0, (one ? event_one_o : event_zero_o)});
        if (failures != 0)
            end_sim;
    endtask : wait_ev
    task t_rates;
        chk("idle count", 16'h0, up_counter_o);
        mode_field_high_i = 1;
        for (int s = 0; s < 4; s++) begin
            {clock_select_high_i, clock_select_low_i} = 2'(s);
            cyc(3);
            v = up_counter_o;
            cyc(8);
            chk("count step", s == 3 ? 16'h0 : 16'(v + (16'h8 >> s)), up_counter_o);
        end
        {clock_select_high_i, clock_select_low_i} = 2'h0;
    endtask : t_rates
    task t_capture;
        edge_toggle_enable_i = 1;
        v = {15'h0, timer_output_pin_o};
        src.drive(0, 1, 0);
        wait_ev(1);
        chk("clear on capture", 16'h0, up_counter_o);
        chk("edge toggle", ~v & 16'h1, {15'h0, timer_output_pin_o});
        cyc(1);
        chk("restart", 16'h1, up_counter_o);
        edge_toggle_enable_i = 0;
    endtask : t_capture
    task t_width;
        reverse_phase_capture_sel_i = 1;
        primary_edge_sel_i = 2'h0;
        e = n0;
        src.drive(0, 0, 20);
        src.drive(0, 1, 30);
        src.drive(0, 0, 0);
        wait_ev(1);
        chk("high width", 16'h001E, 16'(capcomp_reg_one_o - capcomp_reg_zero_o));
        chk("reverse event", 16'h0, 16'(n0 - e));
    endtask : t_width
    task t_secondary;
        {secondary_edge_sel_high_i, secondary_edge_sel_low_i} = 2'h3;
        for (int r = 0; r < 2; r++) begin
            reverse_phase_capture_sel_i = r[0];
            v = capcomp_reg_zero_o;
            e = n0;
            src.drive(1, ~r[0], 10);
            chk("sec event", 16'h1, 16'(n0 - e));
            chk("sec capture", 16'(r == 0), 16'(capcomp_reg_zero_o !== v));
            chk("pin off", 16'h0, {15'h0, timer_output_pin_o});
        end
        {secondary_edge_sel_high_i, secondary_edge_sel_low_i} = 2'h2;
    endtask : t_secondary
    task t_compare;
        primary_edge_sel_i = 2'h1;
        e = n1;
        src.drive(0, 1, 1);
        src.drive(0, 0, 10);
        chk("glitch", 16'h0, 16'(n1 - e));
        src.drive(0, 1, 8);
        capcomp_zero_capture_i = 0;
        capcomp_reg_zero_we_i = 1;
        cyc(1);
        capcomp_reg_zero_we_i = 0;
        v = {15'h0, timer_output_pin_o};
        wait_ev(0);
        chk("match count", 16'h0041, up_counter_o);
        chk("match toggle", ~v & 16'h1, {15'h0, timer_output_pin_o});
        capcomp_one_capture_i = 0;
        capcomp_reg_one_wdata_i = 16'h0050;
        capcomp_reg_one_we_i = 1;
        cyc(1);
        capcomp_reg_one_we_i = 0;
        v = {15'h0, timer_output_pin_o};
        wait_ev(1);
        chk("match one count", 16'h0051, up_counter_o);
        chk("match one toggle", ~v & 16'h1, {15'h0, timer_output_pin_o});
    endtask : t_compare
    initial begin
        cyc(5);
        rst_i = 0;
        cyc(2);
        t_rates();
        t_capture();
        t_width();
        t_secondary();
        t_compare();
        for (int i = 0; i < 70000 && up_counter_o !== 16'hFFFF; i++)
            cyc(1);
        cyc(1);
        chk("wrap", 16'h0, up_counter_o);
        end_sim();
    end
endmodule : test_edge_clear_capture_timer
`default_nettype wire
